// ===== hdl/mpgp_params.svh
`ifndef MPGP_PARAMS_SVH
`define MPGP_PARAMS_SVH

// special-function addresses of the port latches
`define MPGP_ADDR_PORT0 16'hff00
`define MPGP_ADDR_PORT1 16'hff01
`define MPGP_ADDR_PORT2 16'hff02
`define MPGP_ADDR_PORT8 16'hff08
`define MPGP_ADDR_PORT9 16'hff09

// special-function addresses of the control registers
`define MPGP_ADDR_PORT0_DIRECTION 16'hff20
`define MPGP_ADDR_PORT1_DIRECTION 16'hff21
`define MPGP_ADDR_PORT2_DIRECTION 16'hff22
`define MPGP_ADDR_PORT2_PULLUP_SELECT 16'hff32
`define MPGP_ADDR_GROUP_PULLUP_SELECT 16'hfff7

// reset values
`define MPGP_RST_LATCH 8'h00
`define MPGP_RST_DIRECTION 8'hff
`define MPGP_RST_PULLUP 8'h00

// implemented bits of each register
`define MPGP_IMPL_PORT1 8'h07
`define MPGP_IMPL_PORT2 8'h3f
`define MPGP_IMPL_GROUP_PULLUP 8'h03

// field positions
`define MPGP_FIRST_PORT_PULLUP_ENABLE 0
`define MPGP_SECOND_PORT_PULLUP_ENABLE 1
`define MPGP_PIN_EXT_INTERRUPT_A 3
`define MPGP_PIN_EXT_INTERRUPT_B 4

// unmapped reads
`define MPGP_RDATA_UNMAPPED 8'h00

`endif

// ===== hdl/mpgp_pkg.sv
package mpgp_pkg;

  // one cpu access to the special-function space
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } mpgp_sfr_req_t;

  // levels seen on the input-capable pins
  typedef struct packed {
    logic [7:0] p8;
    logic [5:0] p2;
    logic [2:0] p1;
    logic [7:0] p0;
  } mpgp_pins_t;

  // serial block outputs that may take over port 2 pins 0 and 1
  typedef struct packed {
    logic serial_clock_out;
    logic serial_clock_drive;
    logic serial_out;
    logic serial_out_drive;
  } mpgp_serial_alt_t;

endpackage : mpgp_pkg

// ===== hdl/mpgp_top.sv
`timescale 1ns/1ps
`include "mpgp_params.svh"

// What this block does
// - port 0: eight latched pins, input after reset
// - port 1: three latched pins, input after reset
// - port 2: six pins, per-pin direction and pull-up
// - port 8: open-drain bidirectional, display, input at reset
// - port 9: open-drain output only, display segments
// - direction bit 0 drives, 1 releases pin
// - direction registers reset to all ones
// - direction registers take bit or byte writes
// - group pull-up: one bit per port 0/1
// - group pull-up only on input-mode pins
// - group pull-up resets to zero, bit/byte writable
// - port 2 pull-up per pin, input only
// - port 2 pull-up register resets to zero
// - port 2 pins shared with serial, interrupts, timer
// - output level change on interrupt pins raises request
// - input-mode writes only change the output latch
// - reads give pin in input, latch in output
module mpgp_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire mpgp_pkg::mpgp_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_rdata_valid,
  input wire mpgp_pkg::mpgp_pins_t pins_in,
  output logic [7:0] p0_out,
  output logic [7:0] p0_oe_n,
  output logic [7:0] p0_pullup_en,
  output logic [2:0] p1_out,
  output logic [2:0] p1_oe_n,
  output logic [2:0] p1_pullup_en,
  output logic [5:0] p2_out,
  output logic [5:0] p2_oe_n,
  output logic [5:0] p2_pullup_en,
  output logic [7:0] p8_out,
  output logic [7:0] p8_oe_n,
  output logic [7:0] p9_out,
  output logic [7:0] p9_oe_n,
  input wire mpgp_pkg::mpgp_serial_alt_t serial_alt,
  input wire logic display_seg_en,
  input wire logic [7:0] display_segments_high,
  input wire logic [7:0] display_segments_low,
  output logic serial_clock_pin,
  output logic serial_in_pin,
  output logic ext_interrupt_a,
  output logic ext_interrupt_b,
  output logic remote_timer_input,
  output logic ext_interrupt_a_change,
  output logic ext_interrupt_b_change
);

  // masked byte merge; a full byte write uses an all-ones mask
  function automatic logic [7:0] mpgp_merge(
    input logic [7:0] old_val,
    input logic [7:0] new_val,
    input logic [7:0] mask
  );
    mpgp_merge = (old_val & ~mask) | (new_val & mask);
  endfunction : mpgp_merge

  // output latches, one per port
  logic [7:0] latch0_q;
  logic [7:0] latch0_d;
  logic [7:0] latch1_q;
  logic [7:0] latch1_d;
  logic [7:0] latch2_q;
  logic [7:0] latch2_d;
  logic [7:0] latch8_q;
  logic [7:0] latch8_d;
  logic [7:0] latch9_q;
  logic [7:0] latch9_d;
  // direction registers, 1 = input
  logic [7:0] port0_direction_q;
  logic [7:0] port0_direction_d;
  logic [7:0] port1_direction_q;
  logic [7:0] port1_direction_d;
  logic [7:0] port2_direction_q;
  logic [7:0] port2_direction_d;
  // pull-up option registers
  logic [7:0] group_pullup_select_q;
  logic [7:0] group_pullup_select_d;
  logic [7:0] port2_pullup_select_q;
  logic [7:0] port2_pullup_select_d;
  // read port
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  // two-stage pin synchroniser; stage one feeds stage two only
  mpgp_pkg::mpgp_pins_t sync1_q;
  mpgp_pkg::mpgp_pins_t sync1_d;
  mpgp_pkg::mpgp_pins_t sync2_q;
  mpgp_pkg::mpgp_pins_t sync2_d;
  // previous synchronised level of the interrupt pins
  logic [1:0] int_prev_q;
  logic [1:0] int_prev_d;
  // port 8 drive pattern, from latch or display controller
  logic [7:0] p8_drive;

  // synchroniser next state
  always_comb
  begin
    sync1_d = pins_in;
    sync2_d = sync1_q;
  end

  // synchroniser registers, cleared at reset
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // register writes; decode is exact, unmapped writes do nothing
  always_comb
  begin
    latch0_d = latch0_q;
    latch1_d = latch1_q;
    latch2_d = latch2_q;
    latch8_d = latch8_q;
    latch9_d = latch9_q;
    port0_direction_d = port0_direction_q;
    port1_direction_d = port1_direction_q;
    port2_direction_d = port2_direction_q;
    group_pullup_select_d = group_pullup_select_q;
    port2_pullup_select_d = port2_pullup_select_q;
    if (sfr_req.wr)
    begin
      case (sfr_req.addr)
        // latches take the write in any mode; pin only follows if driven
        `MPGP_ADDR_PORT0: latch0_d = mpgp_merge(latch0_q, sfr_req.wdata, sfr_req.wmask);
        `MPGP_ADDR_PORT1: latch1_d = mpgp_merge(latch1_q, sfr_req.wdata, sfr_req.wmask) &
                                     `MPGP_IMPL_PORT1;
        `MPGP_ADDR_PORT2: latch2_d = mpgp_merge(latch2_q, sfr_req.wdata, sfr_req.wmask) &
                                     `MPGP_IMPL_PORT2;
        `MPGP_ADDR_PORT8: latch8_d = mpgp_merge(latch8_q, sfr_req.wdata, sfr_req.wmask);
        `MPGP_ADDR_PORT9: latch9_d = mpgp_merge(latch9_q, sfr_req.wdata, sfr_req.wmask);
        // each direction register written on its own, bit or byte
        `MPGP_ADDR_PORT0_DIRECTION:
          port0_direction_d = mpgp_merge(port0_direction_q, sfr_req.wdata, sfr_req.wmask);
        // unused direction bits held at one
        `MPGP_ADDR_PORT1_DIRECTION:
          port1_direction_d = mpgp_merge(port1_direction_q, sfr_req.wdata, sfr_req.wmask) |
                              ~`MPGP_IMPL_PORT1;
        `MPGP_ADDR_PORT2_DIRECTION:
          port2_direction_d = mpgp_merge(port2_direction_q, sfr_req.wdata, sfr_req.wmask) |
                              ~`MPGP_IMPL_PORT2;
        // unused pull-up bits held at zero
        `MPGP_ADDR_GROUP_PULLUP_SELECT:
          group_pullup_select_d = mpgp_merge(group_pullup_select_q, sfr_req.wdata,
                                             sfr_req.wmask) & `MPGP_IMPL_GROUP_PULLUP;
        `MPGP_ADDR_PORT2_PULLUP_SELECT:
          port2_pullup_select_d = mpgp_merge(port2_pullup_select_q, sfr_req.wdata,
                                             sfr_req.wmask) & `MPGP_IMPL_PORT2;
        default: latch0_d = latch0_q; // no register here; the write is dropped
      endcase
    end
  end

  // register file; directions come up all ones so every port 0, 1 and 2 pin is an input
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch0_q <= `MPGP_RST_LATCH;
      latch1_q <= `MPGP_RST_LATCH;
      latch2_q <= `MPGP_RST_LATCH;
      latch8_q <= `MPGP_RST_LATCH;
      latch9_q <= `MPGP_RST_LATCH;
      port0_direction_q <= `MPGP_RST_DIRECTION;
      port1_direction_q <= `MPGP_RST_DIRECTION;
      port2_direction_q <= `MPGP_RST_DIRECTION;
      group_pullup_select_q <= `MPGP_RST_PULLUP;
      port2_pullup_select_q <= `MPGP_RST_PULLUP;
    end
    else
    begin
      latch0_q <= latch0_d;
      latch1_q <= latch1_d;
      latch2_q <= latch2_d;
      latch8_q <= latch8_d;
      latch9_q <= latch9_d;
      port0_direction_q <= port0_direction_d;
      port1_direction_q <= port1_direction_d;
      port2_direction_q <= port2_direction_d;
      group_pullup_select_q <= group_pullup_select_d;
      port2_pullup_select_q <= port2_pullup_select_d;
    end
  end

  // read mux: input-mode bits show the pin, output-mode bits the latch
  always_comb
  begin
    rvalid_d = sfr_req.rd;
    rdata_d = rdata_q;
    if (sfr_req.rd)
    begin
      case (sfr_req.addr)
        `MPGP_ADDR_PORT0:
          rdata_d = (port0_direction_q & sync2_q.p0) | (~port0_direction_q & latch0_q);
        `MPGP_ADDR_PORT1:
          rdata_d = ((port1_direction_q & {5'h00, sync2_q.p1}) |
                     (~port1_direction_q & latch1_q)) & `MPGP_IMPL_PORT1;
        `MPGP_ADDR_PORT2:
          rdata_d = ((port2_direction_q & {2'h0, sync2_q.p2}) |
                     (~port2_direction_q & latch2_q)) & `MPGP_IMPL_PORT2;
        // open-drain port: released bits read the pin
        `MPGP_ADDR_PORT8: rdata_d = (p8_drive & latch8_q) | (~p8_drive & sync2_q.p8);
        // output-only port: always the latch
        `MPGP_ADDR_PORT9: rdata_d = latch9_q;
        `MPGP_ADDR_PORT0_DIRECTION: rdata_d = port0_direction_q;
        `MPGP_ADDR_PORT1_DIRECTION: rdata_d = port1_direction_q;
        `MPGP_ADDR_PORT2_DIRECTION: rdata_d = port2_direction_q;
        `MPGP_ADDR_GROUP_PULLUP_SELECT: rdata_d = group_pullup_select_q;
        `MPGP_ADDR_PORT2_PULLUP_SELECT: rdata_d = port2_pullup_select_q;
        default: rdata_d = `MPGP_RDATA_UNMAPPED;
      endcase
    end
  end

  // read data held until the next read
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= `MPGP_RDATA_UNMAPPED;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign sfr_rdata_valid = rvalid_q;

  // port 0: direction bit low enables the buffer, so oe_n is the bit itself
  assign p0_out = latch0_q;
  assign p0_oe_n = port0_direction_q;
  // port 1
  assign p1_out = latch1_q[2:0];
  assign p1_oe_n = port1_direction_q[2:0];

  // group pull-ups, gated per pin by input mode
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_port0_pullup
      assign p0_pullup_en[gi] = group_pullup_select_q[`MPGP_FIRST_PORT_PULLUP_ENABLE] &
                                port0_direction_q[gi];
    end
    for (gi = 0; gi < 3; gi++)
    begin : g_port1_pullup
      assign p1_pullup_en[gi] = group_pullup_select_q[`MPGP_SECOND_PORT_PULLUP_ENABLE] &
                                port1_direction_q[gi];
    end
  endgenerate

  // port 2 pins 0/1: serial block takes the level whenever its drive bit is set, in either mode
  assign p2_out[0] = serial_alt.serial_clock_drive ? serial_alt.serial_clock_out :
                     latch2_q[0];
  assign p2_out[1] = serial_alt.serial_out_drive ? serial_alt.serial_out : latch2_q[1];
  assign p2_out[5:2] = latch2_q[5:2];
  assign p2_oe_n = port2_direction_q[5:0];

  // port 2 per-pin pull-up; never on a driven or alternate-output pin
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_port2_pullup
      // only pins 0 and 1 carry an alternate output
      logic alt_drive;
      assign alt_drive = (gi == 0) ? serial_alt.serial_clock_drive :
                         (gi == 1) ? serial_alt.serial_out_drive : 1'b0;
      assign p2_pullup_en[gi] = port2_pullup_select_q[gi] & port2_direction_q[gi] &
                                ~alt_drive;
    end
  endgenerate

  // alternate inputs see the synchronised pin whatever the mode;
  // interrupt and timer use relies on software leaving the pin an input
  assign serial_clock_pin = sync2_q.p2[0];
  assign serial_in_pin = sync2_q.p2[2];
  assign ext_interrupt_a = sync2_q.p2[`MPGP_PIN_EXT_INTERRUPT_A];
  assign ext_interrupt_b = sync2_q.p2[`MPGP_PIN_EXT_INTERRUPT_B];
  assign remote_timer_input = sync2_q.p2[5];

  // change detector on the interrupt pins; the pad loops back, so a level
  // written in output mode also counts as a request
  always_comb
  begin
    int_prev_d = {sync2_q.p2[`MPGP_PIN_EXT_INTERRUPT_B], sync2_q.p2[`MPGP_PIN_EXT_INTERRUPT_A]};
  end

  // previous level, reset low like the synchroniser so no pulse in reset; a pin high through reset pulses once as it syncs in
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_prev_q <= 2'h0;
    end
    else
    begin
      int_prev_q <= int_prev_d;
    end
  end

  assign ext_interrupt_a_change = int_prev_d[0] ^ int_prev_q[0];
  assign ext_interrupt_b_change = int_prev_d[1] ^ int_prev_q[1];

  // port 8: p-channel pulls high for a one; latch cleared at reset, so released
  assign p8_drive = display_seg_en ? display_segments_high : latch8_q;
  assign p8_out = p8_drive;
  assign p8_oe_n = ~p8_drive;

  // port 9: always an output; a zero bit simply releases the open drain
  assign p9_out = display_seg_en ? display_segments_low : latch9_q;
  assign p9_oe_n = ~p9_out;

endmodule : mpgp_top

// ===== bench/mpgp_monitor.sv
`timescale 1ns/1ps
// port-level checks, sees only the top ports
module mpgp_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire mpgp_pkg::mpgp_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rdata_valid,
  input wire logic [7:0] p0_oe_n,
  input wire logic [7:0] p0_pullup_en,
  input wire logic [2:0] p1_oe_n,
  input wire logic [2:0] p1_pullup_en,
  input wire logic [5:0] p2_oe_n,
  input wire logic [5:0] p2_pullup_en,
  input wire logic [7:0] p8_out,
  input wire logic [7:0] p8_oe_n,
  input wire logic [7:0] p9_out,
  input wire logic [7:0] p9_oe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // write hit on the first direction register
  wire dir0_wr = sfr_req.wr && sfr_req.addr == 16'hff20;
  a_read_valid_pulse: assert property (
    sfr_req.rd |=> sfr_rdata_valid) else $error("no valid after read");
  a_no_stray_valid: assert property (
    !sfr_req.rd |=> !sfr_rdata_valid) else $error("valid without read");
  a_dir_reset_ones: assert property (
    !$past(rst_n) |-> p0_oe_n == 8'hff && p1_oe_n == 3'h7 && p2_oe_n == 6'h3f)
    else $error("direction not input after reset");
  a_masked_dir_write: assert property (
    dir0_wr |=> ((p0_oe_n ^ $past(sfr_req.wdata)) & $past(sfr_req.wmask)) == 8'h00
      && ((p0_oe_n ^ $past(p0_oe_n)) & ~$past(sfr_req.wmask)) == 8'h00)
    else $error("direction write mask wrong");
  a_p1_dir_high_ones: assert property (
    sfr_req.rd && sfr_req.addr == 16'hff21 |=> sfr_rdata[7:3] == 5'h1f)
    else $error("unused direction bits not one");
  a_group_pu_zeros: assert property (
    sfr_req.rd && sfr_req.addr == 16'hfff7 |=> sfr_rdata[7:2] == 6'h00)
    else $error("unused pull-up bits not zero");
  a_p0_pu_input: assert property ((p0_pullup_en & ~p0_oe_n) == 8'h00)
    else $error("pull-up on driven port 0 pin");
  a_p1_pu_input: assert property ((p1_pullup_en & ~p1_oe_n) == 3'h0)
    else $error("pull-up on driven port 1 pin");
  a_p2_pu_input: assert property ((p2_pullup_en & ~p2_oe_n) == 6'h00)
    else $error("pull-up on driven port 2 pin");
  a_p8_open_drain: assert property (p8_oe_n == ~p8_out)
    else $error("port 8 drive not open drain");
  a_p9_open_drain: assert property (p9_oe_n == ~p9_out)
    else $error("port 9 drive not open drain");
  c_byte_write: cover property (dir0_wr && sfr_req.wmask == 8'hff);
  c_bit_write: cover property (dir0_wr && sfr_req.wmask == 8'h01);
  c_pullup_on: cover property (p0_pullup_en != 8'h00);
endmodule : mpgp_monitor

// ===== bench/mpgp_pin_model.sv
`timescale 1ns/1ps
// board side of the pins: drivers, pull-ups, floating lines
module mpgp_pin_model (
  input wire logic clk_sys,
  input wire mpgp_pkg::mpgp_pins_t drv,
  input wire mpgp_pkg::mpgp_pins_t den,
  input wire mpgp_pkg::mpgp_pins_t pu,
  input wire mpgp_pkg::mpgp_pins_t ext_val,
  input wire mpgp_pkg::mpgp_pins_t ext_en,
  output mpgp_pkg::mpgp_pins_t pins
);
  logic [24:0] noise_q; // released lines wander, never hold a stale level
  initial noise_q = 25'h0;
  always @(posedge clk_sys) noise_q <= ~noise_q;
  // device drive wins, then board drive, then pull-up, else noise
  assign pins = mpgp_pkg::mpgp_pins_t'((drv & den) | (~den & ext_en & ext_val)
    | (~den & ~ext_en & (pu | noise_q)));
endmodule : mpgp_pin_model

// ===== bench/testbench.sv
`timescale 1ns/1ps
`include "mpgp_params.svh"
module testbench;
  logic clk_sys;
  logic rst_n;
  mpgp_pkg::mpgp_sfr_req_t sfr_req;
  mpgp_pkg::mpgp_pins_t pins_in, ext_val, ext_en, drv, den, pu;
  logic [7:0] sfr_rdata, p0_out, p0_oe_n, p0_pullup_en, p8_out, p8_oe_n, p9_out, p9_oe_n;
  logic [2:0] p1_out, p1_oe_n, p1_pullup_en;
  logic [5:0] p2_out, p2_oe_n, p2_pullup_en;
  logic sfr_rdata_valid, int_a, int_a_chg;
  mpgp_pkg::mpgp_serial_alt_t salt; // serial block outputs onto port 2
  logic dsp_en, sck_pin, si_pin, int_b, int_b_chg, tmr_in;
  logic [7:0] seg_hi, seg_lo; // display segment patterns
  int err_total, samples_checked, cycles, i, k;
  logic [31:0] rng;
  logic [7:0] d, m;
  logic [7:0] sh [10]; // shadow of registers and latches
  logic [15:0] adr [10] = '{16'hff20, 16'hff21, 16'hff22, 16'hff32, 16'hfff7,
    16'hff00, 16'hff01, 16'hff02, 16'hff08, 16'hff09};
  logic [7:0] impl [10] = '{8'hff, 8'h07, 8'h3f, 8'h3f, 8'h03,
    8'hff, 8'h07, 8'h3f, 8'hff, 8'hff};
  mpgp_top dut_u (.clk_sys, .rst_n, .sfr_req, .sfr_rdata, .sfr_rdata_valid, .pins_in,
    .p0_out, .p0_oe_n, .p0_pullup_en, .p1_out, .p1_oe_n, .p1_pullup_en,
    .p2_out, .p2_oe_n, .p2_pullup_en, .p8_out, .p8_oe_n, .p9_out, .p9_oe_n,
    .serial_alt(salt), .display_seg_en(dsp_en), .display_segments_high(seg_hi),
    .display_segments_low(seg_lo), .serial_clock_pin(sck_pin), .serial_in_pin(si_pin),
    .ext_interrupt_a(int_a), .ext_interrupt_b(int_b), .remote_timer_input(tmr_in),
    .ext_interrupt_a_change(int_a_chg), .ext_interrupt_b_change(int_b_chg));
  assign drv = '{p8_out, p2_out, p1_out, p0_out};
  assign den = '{~p8_oe_n, ~p2_oe_n, ~p1_oe_n, ~p0_oe_n};
  assign pu = '{8'h00, p2_pullup_en, p1_pullup_en, p0_pullup_en};
  mpgp_pin_model pin_u (.clk_sys, .drv, .den, .pu, .ext_val, .ext_en, .pins(pins_in));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // port 8 drive pattern: display segments while shown, else the latch
  function automatic logic [7:0] p8_pat();
    return dsp_en ? seg_hi : sh[8];
  endfunction : p8_pat
  // expected read value: latch on driven bits, pin on released ones
  function automatic logic [7:0] exp_rd(int j);
    case (j)
      0, 1, 2: return sh[j] | ~impl[j];
      5: return (sh[5] & ~sh[0]) | (ext_val.p0 & sh[0]);
      6: return (sh[6] & ~sh[1]) | ({5'h00, ext_val.p1} & sh[1]);
      7: return (sh[7] & ~sh[2]) | ({2'h0, ext_val.p2} & sh[2]);
      8: return (p8_pat() & sh[8]) | (~p8_pat() & ext_val.p8);
      default: return sh[j];
    endcase
  endfunction : exp_rd
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // one write cycle, strobe held across exactly one edge
  task automatic wsh(int j, logic [15:0] a, logic [7:0] wd, logic [7:0] wm);
    @(posedge clk_sys);
    sfr_req <= '{a, 1'b1, 1'b0, wd, wm};
    @(posedge clk_sys);
    sfr_req.wr <= 1'b0;
    if (j < 10) sh[j] = ((sh[j] & ~wm) | (wd & wm)) & impl[j];
  endtask : wsh
  task automatic rd(logic [15:0] a, output logic [7:0] rv);
    @(posedge clk_sys);
    sfr_req <= '{a, 1'b0, 1'b1, 8'h00, 8'h00};
    @(posedge clk_sys);
    sfr_req.rd <= 1'b0;
    #1;
    chk("rdata_valid", sfr_rdata_valid, 1'b1);
    rv = sfr_rdata;
  endtask : rd
  task automatic chk_out;
    logic [5:0] alt2; // port 2 pins taken by the serial block
    logic [5:0] p2e; // expected port 2 output pattern
    alt2 = {4'h0, salt.serial_out_drive, salt.serial_clock_drive};
    p2e = sh[7][5:0];
    if (salt.serial_clock_drive) p2e[0] = salt.serial_clock_out;
    if (salt.serial_out_drive) p2e[1] = salt.serial_out;
    chk("p0_oe_n", p0_oe_n, sh[0]);
    chk("p1_oe_n", p1_oe_n, sh[1][2:0]);
    chk("p2_oe_n", p2_oe_n, sh[2][5:0]);
    chk("p0_pu", p0_pullup_en, {8{sh[4][0]}} & sh[0]);
    chk("p1_pu", p1_pullup_en, {3{sh[4][1]}} & sh[1][2:0]);
    chk("p2_pu", p2_pullup_en, sh[3][5:0] & sh[2][5:0] & ~alt2);
    chk("p0_out", p0_out, sh[5]);
    chk("p1_out", p1_out, sh[6][2:0]);
    chk("p2_out", p2_out, p2e);
    chk("p8_out", p8_out, p8_pat());
    chk("p8_oe_n", p8_oe_n, ~p8_pat());
    chk("p9_out", p9_out, dsp_en ? seg_lo : sh[9]);
    chk("p9_oe_n", p9_oe_n, ~(dsp_en ? seg_lo : sh[9]));
  endtask : chk_out
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    sfr_req = '0;
    ext_val = '0;
    ext_en = '1;
    salt = '0;
    dsp_en = 1'b0;
    seg_hi = 8'h00;
    seg_lo = 8'h00;
    rng = 32'h0001_39ef;
    for (k = 0; k < 10; k++) sh[k] = (k < 3) ? impl[k] : 8'h00;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk_out();
    for (k = 0; k < 10; k++)
    begin
      rd(adr[k], d);
      chk("reset_rd", d, exp_rd(k));
    end
    // random byte and bit writes, unmapped ones among them
    repeat (60)
    begin
      // pins, serial takeover and display pattern all move at one edge
      @(posedge clk_sys);
      rng = xs(rng);
      ext_val <= mpgp_pkg::mpgp_pins_t'(rng[24:0]);
      salt <= mpgp_pkg::mpgp_serial_alt_t'(rng[28:25]);
      dsp_en <= rng[29];
      rng = xs(rng);
      seg_hi <= rng[7:0];
      seg_lo <= rng[15:8];
      rng = xs(rng);
      i = rng[3:0] % 11;
      d = rng[15:8];
      m = rng[16] ? 8'hff : 8'h01 << rng[19:17];
      wsh(i, (i == 10) ? 16'hff40 : adr[i], d, m);
      // a pin just released by a direction write needs the sync delay
      repeat (2) @(posedge clk_sys);
      k = rng[23:20] % 10;
      rd(adr[k], d);
      chk("rand_rd", d, exp_rd(k));
      chk_out();
    end
    rd(16'hff40, d);
    chk("unmapped", d, 8'h00);
    // undriven port 0 pins pulled high only through group pull-up
    wsh(4, 16'hfff7, 8'h01, 8'h01);
    wsh(0, 16'hff20, 8'hff, 8'hff);
    ext_en.p0 <= 8'h00;
    // pulled level reaches the read path only after the synchroniser
    repeat (2) @(posedge clk_sys);
    rd(adr[5], d);
    chk("pullup_rd", d, 8'hff);
    // level change on an interrupt-capable pin gives one pulse
    wsh(2, 16'hff22, 8'hff, 8'hff);
    // let any pulse from pins just released by that write die out first
    repeat (4) @(posedge clk_sys);
    ext_val.p2[4:3] <= ~ext_val.p2[4:3];
    for (k = 0; k < 5; k++)
    begin
      @(posedge clk_sys);
      #1;
      chk("int_a_chg", int_a_chg, k == 1);
      chk("int_b_chg", int_b_chg, k == 1);
    end
    chk("int_a", int_a, ext_val.p2[3]);
    chk("int_b", int_b, ext_val.p2[4]);
    chk("sck_pin", sck_pin, ext_val.p2[0]);
    chk("si_pin", si_pin, ext_val.p2[2]);
    chk("tmr_in", tmr_in, ext_val.p2[5]);
    report_and_stop();
  end
endmodule : testbench
bind mpgp_top mpgp_monitor mon_u (.clk_sys, .rst_n, .sfr_req, .sfr_rdata, .sfr_rdata_valid,
  .p0_oe_n, .p0_pullup_en, .p1_oe_n, .p1_pullup_en, .p2_oe_n, .p2_pullup_en,
  .p8_out, .p8_oe_n, .p9_out, .p9_oe_n);
